// ==== rtl/rcfm_defs.svh ====
`ifndef RCFM_DEFS_SVH
`define RCFM_DEFS_SVH

// Clock and timing
`define RCFM_CLK_PERIOD_NS   100
`define RCFM_INIT_US         50
`define RCFM_INIT_CYCLES \
	((`RCFM_INIT_US * 1000 + `RCFM_CLK_PERIOD_NS - 1) / `RCFM_CLK_PERIOD_NS)
`define RCFM_WINDOW_US       100
`define RCFM_WINDOW_CYCLES   ((`RCFM_WINDOW_US * 1000) / `RCFM_CLK_PERIOD_NS)

// Tolerance band, fixed from the nominal reference frequency
`define RCFM_NOM_REF_MHZ     25
`define RCFM_NOM_EDGES       (`RCFM_WINDOW_US * `RCFM_NOM_REF_MHZ)
`define RCFM_TOL_PCT         2
`define RCFM_TOL_EDGES       ((`RCFM_NOM_EDGES * `RCFM_TOL_PCT) / 100)
`define RCFM_MIN_EDGES       1

// Degraded free-run generator half period in clock cycles
`define RCFM_FREERUN_HALF    4

// Register byte offsets
`define RCFM_OFF_STATUS      8'h00
`define RCFM_OFF_IRQ_STAT    8'h04
`define RCFM_OFF_IRQ_MASK    8'h08
`define RCFM_OFF_CTRL        8'h0C
`define RCFM_OFF_DIFF        8'h10

// Status register fields
`define RCFM_ST_FAULT        0
`define RCFM_ST_INIT_DONE    1
`define RCFM_ST_FREERUN      2
`define RCFM_ST_PRI_BAD      3
`define RCFM_ST_BAK_BAD      4
`define RCFM_ST_LOCKED       5
`define RCFM_ST_SEL_LSB      6
`define RCFM_ST_PIN          8

// Interrupt status and mask fields
`define RCFM_IRQ_W           4
`define RCFM_IRQ_FAULT_SET   0
`define RCFM_IRQ_FAULT_CLR   1
`define RCFM_IRQ_FREERUN     2
`define RCFM_IRQ_INIT_DONE   3

// Control register fields
`define RCFM_CTRL_CLR_BAD    0
`define RCFM_CTRL_OUTEN_LSB  8
`define RCFM_OUTEN_W         8

// Reset values
`define RCFM_IRQ_MASK_RST    4'h0
`define RCFM_OUTEN_RST       8'h00

// Configuration words fetched at start-up
`define RCFM_NVM_WORDS       2
`define RCFM_NVM_AW          4
`define RCFM_NVM_MASK_IDX    4'h0
`define RCFM_NVM_OUTEN_IDX   4'h1

`endif

// ==== rtl/rcfm_pkg.sv ====
package rcfm_pkg;

	typedef enum logic [1:0] {
		RCFM_SRC_NONE     = 2'h0,
		RCFM_SRC_BACKUP   = 2'h1,
		RCFM_SRC_PRIMARY  = 2'h2,
		RCFM_SRC_FEEDBACK = 2'h3
	} rcfm_src_t;

	typedef enum logic [2:0] {
		RCFM_INIT_LOAD   = 3'h1,
		RCFM_INIT_SETTLE = 3'h2,
		RCFM_INIT_RUN    = 3'h4
	} rcfm_init_st_t;

endpackage

// ==== rtl/rcfm_freq_meter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rcfm_defs.svh"

module rcfm_freq_meter #(
	parameter int WIN_CYCLES = `RCFM_WINDOW_CYCLES,
	parameter int CNT_W      = 16
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Sampled reference and feedback levels
	input  wire logic             ref_in,
	input  wire logic             fb_in,
	// Result of each window
	output logic                  win_done,
	output logic [CNT_W-1:0]      ref_count,
	output logic [CNT_W-1:0]      diff_mag
);

	localparam int WW = $clog2(WIN_CYCLES + 1);

	if (WIN_CYCLES < 2 || WIN_CYCLES >= (2 ** CNT_W)) begin : g_bad_win
		$error("rcfm_freq_meter: window does not fit the counters");
	end

	function automatic logic [CNT_W-1:0] abs_diff(
		input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b
	);
		abs_diff = (a > b) ? (a - b) : (b - a);
	endfunction

	logic [WW-1:0]    win_cnt;
	logic             ref_q;
	logic             fb_q;
	logic [CNT_W-1:0] ref_cnt;
	logic [CNT_W-1:0] fb_cnt;

	wire              ref_rise     = ref_in & ~ref_q;
	wire              fb_rise      = fb_in & ~fb_q;
	wire              win_last     = win_cnt == WW'(WIN_CYCLES - 1);
	wire [CNT_W-1:0]  next_ref_cnt = ref_cnt + CNT_W'(ref_rise);
	wire [CNT_W-1:0]  next_fb_cnt  = fb_cnt + CNT_W'(fb_rise);

	always_ff @(posedge clk) begin
		if (srst) begin
			ref_q <= 1'b0;
			fb_q  <= 1'b0;
		end else begin
			ref_q <= ref_in;
			fb_q  <= fb_in;
		end
	end

	// Windows run back to back so the check never stops
	always_ff @(posedge clk) begin
		if (srst || win_last) begin
			win_cnt <= '0;
			ref_cnt <= '0;
			fb_cnt  <= '0;
		end else begin
			win_cnt <= win_cnt + WW'(1);
			ref_cnt <= next_ref_cnt;
			fb_cnt  <= next_fb_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			win_done  <= 1'b0;
			ref_count <= '0;
			diff_mag  <= '0;
		end else begin
			win_done <= win_last;
			if (win_last) begin
				ref_count <= next_ref_cnt;
				diff_mag  <= abs_diff(next_ref_cnt, next_fb_cnt);
			end
		end
	end

endmodule
`default_nettype wire

// ==== rtl/rcfm_clk_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rcfm_defs.svh"

module rcfm_clk_gen #(
	parameter int HALF_CYCLES = `RCFM_FREERUN_HALF
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Run request and generated level
	input  wire logic run,
	output logic      gen_clk
);

	localparam int HW = $clog2(HALF_CYCLES + 1);

	if (HALF_CYCLES < 1) begin : g_bad_half
		$error("rcfm_clk_gen: half period must be at least one cycle");
	end

	logic [HW-1:0] half_cnt;

	wire half_last = half_cnt == HW'(HALF_CYCLES - 1);

	// A fixed divider keeps the period steady, well inside the stability band
	always_ff @(posedge clk) begin
		if (srst || !run) begin
			half_cnt <= '0;
			gen_clk  <= 1'b0;
		end else if (half_last) begin
			half_cnt <= '0;
			gen_clk  <= ~gen_clk;
		end else begin
			half_cnt <= half_cnt + HW'(1);
		end
	end

endmodule
`default_nettype wire

// ==== rtl/rcfm_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rcfm_defs.svh"

// Behaviour
// - Raise the fault flag when reference and feedback differ beyond band.
// - Select 00 none, 01 backup crystal, 10 primary, 11 feedback.
// - A fault never changes the source or acts on its own.
// - The disabled select code always raises the fault flag.
// - With primary and backup both faulted, outputs free-run internally once a source has been live.
// - After power-up, load defaults and configuration words, then settle.
// - All clock outputs stay squelched until start-up has finished.
// - The select pins are ignored until start-up completes.
// - If the chosen source carries no clock, outputs stay low unless free-run mode drives them.
// - Switching sources may glitch the outputs; no glitch-free switch.
// - Band limits are fixed constants from the nominal reference frequency.
// - The monitor checks the reference continuously, window after window.
// - The fault pin is active low open drain: pulls low on fault.
module rcfm_top #(
	parameter int N_OUT       = 7,
	parameter int CNT_W       = 16,
	parameter int INIT_CYCLES = `RCFM_INIT_CYCLES,
	parameter int WIN_CYCLES  = `RCFM_WINDOW_CYCLES,
	parameter int TOL_EDGES   = `RCFM_TOL_EDGES,
	parameter int MIN_EDGES   = `RCFM_MIN_EDGES,
	parameter int FREE_HALF   = `RCFM_FREERUN_HALF
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Register port
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// Interrupt
	output logic                   irq,
	// Configuration memory read port
	output logic [`RCFM_NVM_AW-1:0] nvm_addr,
	output logic                   nvm_rd,
	input  wire logic [31:0]       nvm_rdata,
	// Reference sources, sampled levels
	input  wire logic              crystal_pins_in,
	input  wire logic              primary_clock_input,
	input  wire logic              feedback_clock_input,
	// Source select pins
	input  wire logic              ref_source_select_hi,
	input  wire logic              ref_source_select_lo,
	// Reference to the loop and output clocks
	output logic                   pll_ref_out,
	output logic [N_OUT-1:0]       clk_out,
	output var rcfm_pkg::rcfm_src_t active_source,
	output logic                   degraded_freerun_mode,
	// Open-drain fault pin
	output logic                   freq_fault_flag_n_out,
	output logic                   freq_fault_flag_n_oe_n,
	input  wire logic              freq_fault_flag_n_in
);

	import rcfm_pkg::*;

	localparam int IW = $clog2(INIT_CYCLES + 1);

	if (N_OUT < 1 || N_OUT > `RCFM_OUTEN_W) begin : g_bad_nout
		$error("rcfm_top: output count outside the enable field");
	end
	if (TOL_EDGES < 0 || TOL_EDGES >= (2 ** CNT_W)) begin : g_bad_tol
		$error("rcfm_top: tolerance does not fit the counters");
	end
	if (INIT_CYCLES < 1) begin : g_bad_init
		$error("rcfm_top: start-up time must be at least one cycle");
	end

	localparam logic [CNT_W-1:0] TOL = CNT_W'(TOL_EDGES);
	localparam logic [CNT_W-1:0] MIN = CNT_W'(MIN_EDGES);
	localparam logic [`RCFM_NVM_AW-1:0] NVM_LAST =
		`RCFM_NVM_AW'(`RCFM_NVM_WORDS - 1);

	// Start-up sequencer
	rcfm_init_st_t             init_st;
	rcfm_init_st_t             next_init_st;
	logic [IW-1:0]             init_cnt;
	logic                      nvm_rd_q;
	logic [`RCFM_NVM_AW-1:0]   nvm_addr_q;

	// Monitor state
	rcfm_src_t                 act_sel;
	logic                      band_fault;
	logic                      fault_q;
	logic                      locked_once;
	logic                      pri_bad;
	logic                      bak_bad;
	logic                      freerun_q;
	logic                      run_q;

	// Software registers
	logic [`RCFM_IRQ_W-1:0]    irq_stat;
	logic [`RCFM_IRQ_W-1:0]    irq_mask;
	logic [`RCFM_OUTEN_W-1:0]  out_en;
	logic [31:0]               rd_mux;

	// Meter and generator results
	logic                      win_done;
	logic [CNT_W-1:0]          ref_count;
	logic [CNT_W-1:0]          diff_mag;
	logic                      gen_clk;

	wire init_run    = init_st == RCFM_INIT_RUN;
	wire settle_last = init_cnt == IW'(INIT_CYCLES - 1);
	wire nvm_last    = nvm_addr == NVM_LAST;

	always_comb begin
		next_init_st = init_st;
		case (init_st)
			RCFM_INIT_LOAD:   if (nvm_last) next_init_st = RCFM_INIT_SETTLE;
			RCFM_INIT_SETTLE: if (settle_last) next_init_st = RCFM_INIT_RUN;
			RCFM_INIT_RUN:    next_init_st = RCFM_INIT_RUN;
			default:          next_init_st = RCFM_INIT_LOAD;
		endcase
	end

	// Fetch configuration words, then wait out the rest of start-up
	always_ff @(posedge clk) begin
		if (srst) begin
			init_st    <= RCFM_INIT_LOAD;
			init_cnt   <= '0;
			nvm_addr   <= '0;
			nvm_rd_q   <= 1'b0;
			nvm_addr_q <= '0;
		end else begin
			init_st    <= next_init_st;
			nvm_rd_q   <= nvm_rd;
			nvm_addr_q <= nvm_addr;
			if (nvm_rd && !nvm_last)
				nvm_addr <= nvm_addr + `RCFM_NVM_AW'(1);
			if (init_st == RCFM_INIT_SETTLE)
				init_cnt <= init_cnt + IW'(1);
		end
	end

	assign nvm_rd = init_st == RCFM_INIT_LOAD;

	// Select decode and reference routing
	wire [1:0] pin_sel = {ref_source_select_hi, ref_source_select_lo};
	wire sel_none = act_sel == RCFM_SRC_NONE;
	wire sel_pri  = act_sel == RCFM_SRC_PRIMARY;
	wire sel_bak  = act_sel == RCFM_SRC_BACKUP;
	wire sel_fb   = act_sel == RCFM_SRC_FEEDBACK;

	// A plain mux: a switch may cut a pulse short
	wire pll_ref = (sel_bak & crystal_pins_in)
		| (sel_pri & primary_clock_input)
		| (sel_fb & feedback_clock_input);

	always_ff @(posedge clk) begin
		if (srst) begin
			act_sel     <= RCFM_SRC_NONE;
			pll_ref_out <= 1'b0;
		end else begin
			if (init_run)
				act_sel <= rcfm_src_t'(pin_sel);
			pll_ref_out <= pll_ref;
		end
	end

	rcfm_freq_meter #(
		.WIN_CYCLES (WIN_CYCLES),
		.CNT_W      (CNT_W)
	) u_meter (
		.clk       (clk),
		.srst      (srst),
		.ref_in    (pll_ref),
		.fb_in     (feedback_clock_input),
		.win_done  (win_done),
		.ref_count (ref_count),
		.diff_mag  (diff_mag)
	);

	// Window verdicts; a dead source counts as out of band
	wire win_out  = (diff_mag > TOL) || (ref_count < MIN);
	wire win_eval = win_done && init_run;
	wire src_live = win_eval && !sel_none && (ref_count >= MIN);

	always_ff @(posedge clk) begin
		if (srst) begin
			band_fault  <= 1'b0;
			locked_once <= 1'b0;
		end else begin
			if (win_eval)
				band_fault <= win_out;
			if (src_live)
				locked_once <= 1'b1;
		end
	end

	// Fault never feeds back into act_sel: the controller decides
	wire fault_now = !init_run || sel_none || band_fault;

	// Register decode
	wire hit_status   = reg_addr == `RCFM_OFF_STATUS;
	wire hit_irq_stat = reg_addr == `RCFM_OFF_IRQ_STAT;
	wire hit_irq_mask = reg_addr == `RCFM_OFF_IRQ_MASK;
	wire hit_ctrl     = reg_addr == `RCFM_OFF_CTRL;
	wire hit_diff     = reg_addr == `RCFM_OFF_DIFF;

	// Per-source fault memory; the hardware set beats a software clear
	wire clr_bad = reg_wr && hit_ctrl && reg_wdata[`RCFM_CTRL_CLR_BAD];
	wire set_pri = win_eval && sel_pri && win_out;
	wire set_bak = win_eval && sel_bak && win_out;
	wire ok_pri  = win_eval && sel_pri && !win_out;
	wire ok_bak  = win_eval && sel_bak && !win_out;
	wire next_freerun = pri_bad && bak_bad;

	always_ff @(posedge clk) begin
		if (srst) begin
			pri_bad   <= 1'b0;
			bak_bad   <= 1'b0;
			freerun_q <= 1'b0;
			fault_q   <= 1'b1;
			run_q     <= 1'b0;
		end else begin
			pri_bad   <= set_pri || (pri_bad && !ok_pri && !clr_bad);
			bak_bad   <= set_bak || (bak_bad && !ok_bak && !clr_bad);
			freerun_q <= next_freerun;
			fault_q   <= fault_now;
			run_q     <= init_run;
		end
	end

	assign degraded_freerun_mode = freerun_q;

	rcfm_clk_gen #(
		.HALF_CYCLES (FREE_HALF)
	) u_freerun (
		.clk     (clk),
		.srst    (srst),
		.run     (freerun_q),
		.gen_clk (gen_clk)
	);

	// Output clocks: squelched during start-up and until a live source
	wire out_ok  = init_run && locked_once;
	wire out_lvl = freerun_q ? gen_clk : pll_ref;

	always_ff @(posedge clk) begin
		if (srst)
			clk_out <= '0;
		else if (out_ok)
			clk_out <= {N_OUT{out_lvl}} & out_en[N_OUT-1:0];
		else
			clk_out <= '0;
	end

	assign active_source = act_sel;

	// Open drain: the level is always low, only the enable moves
	assign freq_fault_flag_n_out  = 1'b0;
	assign freq_fault_flag_n_oe_n = ~fault_q;

	wire nvm_mask_cap  = nvm_rd_q && (nvm_addr_q == `RCFM_NVM_MASK_IDX);
	wire nvm_outen_cap = nvm_rd_q && (nvm_addr_q == `RCFM_NVM_OUTEN_IDX);

	// Events for the sticky status
	wire [`RCFM_IRQ_W-1:0] irq_ev;
	assign irq_ev[`RCFM_IRQ_FAULT_SET] = fault_now && !fault_q;
	assign irq_ev[`RCFM_IRQ_FAULT_CLR] = !fault_now && fault_q;
	assign irq_ev[`RCFM_IRQ_FREERUN]   = next_freerun && !freerun_q;
	assign irq_ev[`RCFM_IRQ_INIT_DONE] = init_run && !run_q;

	wire [`RCFM_IRQ_W-1:0] irq_clr = (reg_wr && hit_irq_stat)
		? reg_wdata[`RCFM_IRQ_W-1:0] : '0;

	always_ff @(posedge clk) begin
		if (srst)
			irq_stat <= '0;
		else
			irq_stat <= irq_ev | (irq_stat & ~irq_clr);
	end

	// Start-up words win; a mask or control write in the same cycle is lost
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_mask <= `RCFM_IRQ_MASK_RST;
			out_en   <= `RCFM_OUTEN_RST;
		end else if (nvm_mask_cap) begin
			irq_mask <= nvm_rdata[`RCFM_IRQ_W-1:0];
		end else if (nvm_outen_cap) begin
			out_en <= nvm_rdata[`RCFM_OUTEN_W-1:0];
		end else if (reg_wr && hit_irq_mask) begin
			irq_mask <= reg_wdata[`RCFM_IRQ_W-1:0];
		end else if (reg_wr && hit_ctrl) begin
			out_en <= reg_wdata[`RCFM_CTRL_OUTEN_LSB +: `RCFM_OUTEN_W];
		end
	end

	wire [31:0] status_word;
	assign status_word = {
		23'h0,
		freq_fault_flag_n_in,
		act_sel,
		locked_once,
		bak_bad,
		pri_bad,
		freerun_q,
		init_run,
		fault_q
	};

	always_comb begin
		rd_mux = 32'h0;
		if (hit_status)
			rd_mux = status_word;
		else if (hit_irq_stat)
			rd_mux = {{(32 - `RCFM_IRQ_W){1'b0}}, irq_stat};
		else if (hit_irq_mask)
			rd_mux = {{(32 - `RCFM_IRQ_W){1'b0}}, irq_mask};
		else if (hit_ctrl)
			rd_mux = {16'h0, out_en, 8'h0};
		else if (hit_diff)
			rd_mux = 32'(diff_mag);
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (srst)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
	end

	assign irq = |(irq_stat & irq_mask);

endmodule
`default_nettype wire

// ==== bench/rcfm_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rcfm_defs.svh"
module rcfm_checker #(
	parameter int N_OUT       = 7,
	parameter int INIT_CYCLES = `RCFM_INIT_CYCLES
) (
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    srst,
	// Interrupt and configuration fetch
	input wire logic                    irq,
	input wire logic [`RCFM_NVM_AW-1:0] nvm_addr,
	input wire logic                    nvm_rd,
	// Sources and select pins
	input wire logic                    crystal_pins_in,
	input wire logic                    primary_clock_input,
	input wire logic                    feedback_clock_input,
	input wire logic                    ref_source_select_hi,
	input wire logic                    ref_source_select_lo,
	// Outputs
	input wire logic                    pll_ref_out,
	input wire logic [N_OUT-1:0]        clk_out,
	input wire rcfm_pkg::rcfm_src_t     active_source,
	input wire logic                    degraded_freerun_mode,
	input wire logic                    freq_fault_flag_n_out,
	input wire logic                    freq_fault_flag_n_oe_n
);
	import rcfm_pkg::*;
	logic [1:0]  pins;
	logic        sel_lvl;
	logic [15:0] up_cnt;
	assign pins = {ref_source_select_hi, ref_source_select_lo};
	assign sel_lvl = (active_source == RCFM_SRC_BACKUP) ? crystal_pins_in :
		(active_source == RCFM_SRC_PRIMARY) ? primary_clock_input :
		(active_source == RCFM_SRC_FEEDBACK) ? feedback_clock_input : 1'b0;
	// Saturates so a long run never wraps back into the start-up span
	always_ff @(posedge clk) begin
		if (srst)
			up_cnt <= 16'h0000;
		else if (up_cnt != 16'hFFFF)
			up_cnt <= up_cnt + 16'h0001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	nvm_fetch_a: assert property (
		$fell(srst) |-> nvm_rd && nvm_addr == 4'h0
		##1 nvm_rd && nvm_addr == 4'h1 ##1 !nvm_rd)
		else $error("start-up fetch sequence wrong");
	squelch_init_a: assert property (
		int'(up_cnt) < INIT_CYCLES + 2 |-> clk_out == '0)
		else $error("outputs not squelched during start-up");
	early_ignore_a: assert property (
		int'(up_cnt) < INIT_CYCLES |-> active_source == RCFM_SRC_NONE)
		else $error("select pins honoured during start-up");
	select_follow_a: assert property (
		$changed(active_source) |-> active_source == $past(pins))
		else $error("source changed to a value not on the pins");
	keep_source_a: assert property (
		$rose(!freq_fault_flag_n_oe_n) && $stable(pins)
		|=> $stable(active_source))
		else $error("fault changed the source");
	none_fault_a: assert property (
		(pins == 2'h0)[*3] |-> !freq_fault_flag_n_oe_n)
		else $error("disabled code without fault");
	drain_low_a: assert property (
		!freq_fault_flag_n_oe_n |-> freq_fault_flag_n_out == 1'b0)
		else $error("fault pin driven high");
	ref_route_a: assert property (
		pll_ref_out == $past(sel_lvl))
		else $error("reference not routed from selected source");
	freerun_toggle_a: assert property (
		degraded_freerun_mode && clk_out != '0
		|-> ##[1:5] (clk_out == '0 || !degraded_freerun_mode))
		else $error("outputs stopped in free-run");
	cover property (degraded_freerun_mode);
	cover property ($rose(irq));
	cover property ($changed(active_source));
endmodule
bind rcfm_top rcfm_checker #(.N_OUT(N_OUT), .INIT_CYCLES(INIT_CYCLES))
	u_rcfm_checker (
	.clk(clk), .srst(srst), .irq(irq), .nvm_addr(nvm_addr),
	.nvm_rd(nvm_rd), .crystal_pins_in(crystal_pins_in),
	.primary_clock_input(primary_clock_input),
	.feedback_clock_input(feedback_clock_input),
	.ref_source_select_hi(ref_source_select_hi),
	.ref_source_select_lo(ref_source_select_lo),
	.pll_ref_out(pll_ref_out), .clk_out(clk_out),
	.active_source(active_source),
	.degraded_freerun_mode(degraded_freerun_mode),
	.freq_fault_flag_n_out(freq_fault_flag_n_out),
	.freq_fault_flag_n_oe_n(freq_fault_flag_n_oe_n)
);
`default_nettype wire

// ==== bench/rcfm_safety_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
module rcfm_safety_ctl (
	// Clock
	input wire logic       clk,
	// Commands from the bench
	input wire logic [1:0] cmd_sel,
	input wire logic       failover_en,
	// Open-drain fault pin
	input wire logic       flag_n_out,
	input wire logic       flag_n_oe_n,
	output logic           flag_pin,
	// Select pins
	output logic           sel_hi,
	output logic           sel_lo
);
	logic [1:0] sel_q = 2'h2;
	// Pull-up holds the line high whenever the device lets go
	assign flag_pin = flag_n_oe_n ? 1'b1 : flag_n_out;
	assign sel_hi = sel_q[1];
	assign sel_lo = sel_q[0];
	always @(posedge clk) begin
		if (failover_en && !flag_pin && sel_q == 2'h2)
			sel_q <= 2'h1;
		else if (!failover_en)
			sel_q <= cmd_sel;
	end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "rcfm_defs.svh"
module tb;
	import rcfm_pkg::*;
	typedef struct packed {
		logic [1:0] sel;
		logic [2:0] alive;
		logic       fault;
	} rcfm_row_t;
	localparam int INIT = 20;
	logic        clk, srst, reg_wr, reg_rd, failover_en, flag_pin;
	logic        sel_hi, sel_lo, pri, bak, fb, pll_ref, degraded, irq;
	logic        nvm_rd, od_out, od_oe_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, nvm_rdata, rdv;
	logic [3:0]  nvm_addr;
	logic [6:0]  clk_out;
	logic [1:0]  cmd_sel, ph = 2'h0;
	logic [2:0]  alive;
	rcfm_src_t   act;
	int          mismatches, compares, n;
	rcfm_row_t   rows [7];

	// Free-run half period matches the sources: a toggle every other cycle
	rcfm_top #(.INIT_CYCLES(INIT), .WIN_CYCLES(40), .TOL_EDGES(2),
		.FREE_HALF(2)) u_rcfm_top (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.nvm_addr(nvm_addr), .nvm_rd(nvm_rd), .nvm_rdata(nvm_rdata),
		.crystal_pins_in(bak), .primary_clock_input(pri),
		.feedback_clock_input(fb), .ref_source_select_hi(sel_hi),
		.ref_source_select_lo(sel_lo), .pll_ref_out(pll_ref),
		.clk_out(clk_out), .active_source(act),
		.degraded_freerun_mode(degraded), .freq_fault_flag_n_out(od_out),
		.freq_fault_flag_n_oe_n(od_oe_n), .freq_fault_flag_n_in(flag_pin));
	rcfm_safety_ctl u_rcfm_safety_ctl (
		.clk(clk), .cmd_sel(cmd_sel), .failover_en(failover_en),
		.flag_n_out(od_out), .flag_n_oe_n(od_oe_n), .flag_pin(flag_pin),
		.sel_hi(sel_hi), .sel_lo(sel_lo));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// All sources share one rate, slow enough for the sampled inputs
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		pri <= alive[2] & ph[1];
		bak <= alive[1] & ph[1];
		fb <= alive[0] & ph[1];
		nvm_rdata <= (nvm_addr == 4'h0) ? 32'h0000000F : 32'h000000FF;
	end

	task automatic results;
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wcyc(int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		wcyc(1);
		reg_rd <= 1'b0;
		rdv = reg_rdata;
	endtask
	// Bounded wait for the fault pin to show the wanted state
	task automatic wfault(logic f);
		n = 0;
		while (flag_pin !== !f && n < 300) begin
			wcyc(1);
			n++;
		end
		if (flag_pin !== !f) begin
			chk("fault wait", !f, flag_pin);
			results();
		end
	endtask

	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		mismatches = 0;
		compares = 0;
		alive = 3'h3;
		cmd_sel = 2'h2;
		failover_en = 1'b0;
		rows = '{'{2'h2, 3'h7, 1'b0}, '{2'h1, 3'h7, 1'b0},
			'{2'h3, 3'h7, 1'b0}, '{2'h0, 3'h7, 1'b1},
			'{2'h1, 3'h6, 1'b1}, '{2'h1, 3'h7, 1'b0},
			'{2'h2, 3'h7, 1'b0}};
		wcyc(4);
		srst <= 1'b0;
		wcyc(5);
		chk("early source", 2'h0, act);
		wcyc(INIT + 10);
		chk("run source", 2'h2, act);
		wcyc(120);
		chk("dead outputs", 7'h0, clk_out);
		rd(`RCFM_OFF_STATUS);
		chk("status", 32'h08B, rdv & 32'h1EB);
		rd(`RCFM_OFF_IRQ_MASK);
		chk("mask", 32'hF, rdv);
		rd(`RCFM_OFF_CTRL);
		chk("ctrl", 32'hFF00, rdv & 32'hFF00);
		rd(8'h14);
		chk("unmapped", 32'h0, rdv);
		foreach (rows[i]) begin
			cmd_sel <= rows[i].sel;
			alive <= rows[i].alive;
			wfault(rows[i].fault);
			wcyc(80);
			chk("fault pin", !rows[i].fault, flag_pin);
			chk("source", rows[i].sel, act);
		end
		wr(`RCFM_OFF_IRQ_MASK, 32'h0);
		wr(`RCFM_OFF_IRQ_STAT, 32'hF);
		rd(`RCFM_OFF_IRQ_STAT);
		chk("irq stat clear", 32'h0, rdv);
		cmd_sel <= 2'h0;
		wfault(1'b1);
		rd(`RCFM_OFF_IRQ_STAT);
		chk("irq stat", 32'h1, rdv);
		chk("irq masked", 1'b0, irq);
		wr(`RCFM_OFF_IRQ_MASK, 32'h1);
		chk("irq raised", 1'b1, irq);
		wr(`RCFM_OFF_IRQ_STAT, 32'h1);
		chk("irq cleared", 1'b0, irq);
		// Primary then backup both fail
		cmd_sel <= 2'h2;
		alive <= 3'h1;
		wcyc(120);
		cmd_sel <= 2'h1;
		wcyc(120);
		chk("freerun", 1'b1, degraded);
		n = 0;
		for (int k = 0; k < 40; k++) begin
			rdv[0] = clk_out[0];
			wcyc(1);
			if (clk_out[0] !== rdv[0])
				n++;
		end
		chk("freerun toggles", 32'd20, n);
		// Backup dead, feedback gives one rise per 4 cycles: 10 per window
		rd(`RCFM_OFF_DIFF);
		chk("diff", 32'd10, rdv);
		alive <= 3'h7;
		wcyc(100);
		chk("freerun exit", 1'b0, degraded);
		rd(`RCFM_OFF_STATUS);
		chk("primary bad", 32'h8, rdv & 32'h8);
		wr(`RCFM_OFF_CTRL, 32'h0000FF01);
		rd(`RCFM_OFF_STATUS);
		chk("bad cleared", 32'h0, rdv & 32'h8);
		cmd_sel <= 2'h2;
		wfault(1'b0);
		wcyc(80);
		alive <= 3'h3;
		failover_en <= 1'b1;
		wfault(1'b1);
		wfault(1'b0);
		chk("failover", 2'h1, act);
		srst <= 1'b1;
		wcyc(4);
		srst <= 1'b0;
		wcyc(3);
		chk("reset squelch", 7'h0, clk_out);
		results();
	end
endmodule
`default_nettype wire
